// ---- common/tcs_pkg.sv ----
package tcs_pkg;

   // ----------------------------------------------------------------
   // time base
   // ----------------------------------------------------------------
   localparam int unsigned CLK_HZ = 125_000_000;
   localparam int unsigned TICK_US = 500;                     // one time-base tick
   localparam int unsigned TICK_CYCLES = (CLK_HZ / 1_000_000) * TICK_US;
   localparam int unsigned PULSE_PERIOD_MS = 1000;            // one charge pulse a second
   localparam int unsigned SECOND_TICKS = (PULSE_PERIOD_MS * 1000) / TICK_US;
   localparam int unsigned TOPOFF_PULSE_US = 62500;           // 1/16 of a second
   localparam int unsigned TOPOFF_PULSE_TICKS = TOPOFF_PULSE_US / TICK_US;
   localparam int unsigned TRICKLE_STEP_US = 1000;            // width per select step
   localparam int unsigned TRICKLE_STEP_TICKS = TRICKLE_STEP_US / TICK_US;

   // ----------------------------------------------------------------
   // widths and reset values
   // ----------------------------------------------------------------
   localparam int unsigned TICK_W = 17;
   localparam int unsigned SEC_W = 11;
   localparam int unsigned TIME_W = 16;
   localparam int unsigned SEL_W = 8;
   localparam int unsigned SYNC_STAGES = 2;
   localparam logic [TIME_W-1:0] ELAPSED_RST = 16'h0000;

   // ----------------------------------------------------------------
   // sequencer states, one-hot
   // ----------------------------------------------------------------
   typedef enum logic [6:0] {
      TCS_IDLE     = 7'h01,  // waiting for fast charge to end
      TCS_TOPOFF   = 7'h02,  // top-off pulses, timer running
      TCS_TOP_COLD = 7'h04,  // top-off suspended, trickle, timer paused
      TCS_TOP_HOT  = 7'h08,  // no charge, timer still running
      TCS_TRICKLE  = 7'h10,  // maintenance trickle, no timer
      TCS_OT_HALT  = 7'h20,  // over-temperature stop
      TCS_DONE     = 7'h40   // max cell voltage reached
   } tcs_state_t;

   // comparator results from the analog front end
   typedef struct packed {
      logic cold;              // temperature_input above cold_fault_threshold
      logic hot;               // below hot_fault_threshold
      logic overtemp;          // below overtemp_cutoff_threshold
      logic at_max;            // cell_voltage_input at max_cell_voltage
      logic sense_above_low;   // current_sense_input above sense_low_limit
      logic sense_below_high;  // current_sense_input below sense_high_limit
      logic cap_large;         // timer_capacitor above top-off enable size
      logic res_small;         // timer_resistor below top-off enable size
   } tcs_cmp_t;

   localparam int unsigned CMP_W = $bits(tcs_cmp_t);

endpackage : tcs_pkg

// ---- core/tcs_sequencer.sv ----
`timescale 1ns/1ps
`default_nettype none

module tcs_sequencer
   import tcs_pkg::*;
#(
   parameter int unsigned TICK_CYC = TICK_CYCLES,
   parameter int unsigned SEC_TICKS = SECOND_TICKS
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   input wire logic charge_init,
   input wire logic fast_charge_done,
   input wire logic sleep_mode,
   input wire logic temp_sampling,
   input wire logic [TIME_W-1:0] max_charge_time,
   input wire logic [SEL_W-1:0] trickle_width_sel,
   input wire tcs_cmp_t cmp_raw,
   output logic charge_switch_output,
   output logic status_indicator_out,
   output logic status_indicator_oe,
   output logic timer_pin_pull_low,
   output logic timer_osc_run,
   output tcs_state_t charge_state
);

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   tcs_cmp_t cmp;
   tcs_state_t state_q;
   tcs_state_t state_d;
   logic [TICK_W-1:0] tick_cnt_q;
   logic tick;
   logic [SEC_W-1:0] sec_cnt_q;
   logic sec_wrap;
   logic [TIME_W-1:0] elapsed_q;
   logic expired;
   logic topoff_en;
   logic sense_inside;
   logic pulse_window;
   logic switch_d;

   // ----------------------------------------------------------------
   // functions
   // ----------------------------------------------------------------

   // timer oscillator runs while top-off owns the timer
   function automatic logic timer_running(input tcs_state_t s);
      timer_running = (s == TCS_TOPOFF) || (s == TCS_TOP_HOT);
   endfunction : timer_running

   // pulse width in ticks for each charging state, zero when idle
   function automatic logic [SEC_W-1:0] pulse_ticks(input tcs_state_t s,
                                                      input logic [SEL_W-1:0] sel);
      logic [SEC_W-1:0] w;
      w = '0;
      case (s)
         TCS_TOPOFF: w = SEC_W'(TOPOFF_PULSE_TICKS);
         TCS_TOP_COLD,
         TCS_TRICKLE: w = SEC_W'(sel) * SEC_W'(TRICKLE_STEP_TICKS);
         default: w = '0;
      endcase
      pulse_ticks = w;
   endfunction : pulse_ticks

   // ----------------------------------------------------------------
   // comparator synchronisation
   // ----------------------------------------------------------------
   tcs_sync #(
      .WIDTH(CMP_W)
   ) u_sync (
      .clk(clk),
      .nrst(nrst),
      .ce(ce),
      .async_in(cmp_raw),
      .sync_out(cmp)
   );

   // ----------------------------------------------------------------
   // time base
   // ----------------------------------------------------------------

   // tick divider from the system clock
   assign tick = (tick_cnt_q == TICK_W'(TICK_CYC - 1));

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         tick_cnt_q <= '0;
      end else if (ce) begin
         if (tick) begin
            tick_cnt_q <= '0;
         end else begin
            tick_cnt_q <= tick_cnt_q + TICK_W'(1);
         end
      end
   end

   // one-second pulse frame counted in ticks
   assign sec_wrap = tick && (sec_cnt_q == SEC_W'(SEC_TICKS - 1));

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sec_cnt_q <= '0;
      end else if (ce && tick) begin
         if (sec_wrap) begin
            sec_cnt_q <= '0;
         end else begin
            sec_cnt_q <= sec_cnt_q + SEC_W'(1);
         end
      end
   end

   // ----------------------------------------------------------------
   // top-off timer
   // ----------------------------------------------------------------

   // whole seconds of top-off used so far
   assign expired = (elapsed_q >= max_charge_time);

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         elapsed_q <= ELAPSED_RST;
      end else if (ce) begin
         if (state_q == TCS_IDLE) begin
            elapsed_q <= ELAPSED_RST;
         end else if (timer_running(state_q) && sec_wrap && !expired) begin
            elapsed_q <= elapsed_q + TIME_W'(1);
         end
      end
   end

   // ----------------------------------------------------------------
   // next-state logic
   // ----------------------------------------------------------------

   // capacitor in the middle band counts as disabled
   assign topoff_en = cmp.cap_large && cmp.res_small;

   always_comb begin
      state_d = state_q;
      case (state_q)
         TCS_IDLE: begin
            if (fast_charge_done) begin
               state_d = topoff_en ? TCS_TOPOFF : TCS_TRICKLE;
            end
         end
         TCS_TOPOFF: begin
            if (cmp.at_max) begin
               state_d = TCS_DONE;
            end else if (cmp.overtemp) begin
               state_d = TCS_OT_HALT;
            end else if (expired) begin
               state_d = TCS_TRICKLE;
            end else if (cmp.hot) begin
               state_d = TCS_TOP_HOT;
            end else if (cmp.cold) begin
               state_d = TCS_TOP_COLD;
            end
         end
         TCS_TOP_COLD: begin
            if (cmp.at_max) begin
               state_d = TCS_DONE;
            end else if (cmp.overtemp) begin
               state_d = TCS_OT_HALT;
            end else if (cmp.hot) begin
               state_d = TCS_TOP_HOT;
            end else if (!cmp.cold) begin
               state_d = TCS_TOPOFF;
            end
         end
         TCS_TOP_HOT: begin
            if (cmp.overtemp) begin
               state_d = TCS_OT_HALT;
            end else if (!cmp.hot) begin
               state_d = expired ? TCS_TRICKLE : TCS_TOPOFF;
            end
         end
         TCS_TRICKLE: begin
            if (cmp.at_max) begin
               state_d = TCS_DONE;
            end
            // no timeout here, only max cell voltage or restart leaves
         end
         TCS_OT_HALT: begin
            if (!cmp.hot && !cmp.overtemp) begin
               state_d = TCS_TRICKLE;
            end
         end
         TCS_DONE: begin
            state_d = TCS_DONE;
         end
         default: begin
            state_d = TCS_IDLE;
         end
      endcase
      if (charge_init) begin
         state_d = TCS_IDLE;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state_q <= TCS_IDLE;
      end else if (ce) begin
         state_q <= state_d;
      end
   end

   // ----------------------------------------------------------------
   // charge switch
   // ----------------------------------------------------------------

   // in-band current decision from the sense comparators, no memory between limits
   assign sense_inside = cmp.sense_above_low && cmp.sense_below_high;

   // pulse window at the start of each second
   assign pulse_window = (sec_cnt_q < pulse_ticks(state_q, trickle_width_sel));

   always_comb begin
      switch_d = 1'b0;
      case (state_q)
         TCS_TOPOFF: switch_d = pulse_window;
         TCS_TOP_COLD: switch_d = pulse_window;
         TCS_TRICKLE: switch_d = pulse_window && !cmp.hot && !cmp.overtemp;
         default: switch_d = 1'b0;
      endcase
      // inner current loop and outer voltage clamp
      switch_d = switch_d && sense_inside && !cmp.at_max;
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         charge_switch_output <= 1'b0;
      end else if (ce) begin
         charge_switch_output <= switch_d;
      end
   end

   // ----------------------------------------------------------------
   // status indicator
   // ----------------------------------------------------------------

   // open drain: lit only while fast charge is still running
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         status_indicator_out <= 1'b0;
         status_indicator_oe <= 1'b0;
      end else if (ce) begin
         status_indicator_out <= 1'b0;
         status_indicator_oe <= (state_d == TCS_IDLE);
      end
   end

   // ----------------------------------------------------------------
   // timer pin
   // ----------------------------------------------------------------

   // sawtooth only while the timer counts, otherwise steady
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         timer_pin_pull_low <= 1'b0;
         timer_osc_run <= 1'b0;
      end else if (ce) begin
         timer_pin_pull_low <= sleep_mode ||
                               (temp_sampling && state_d == TCS_IDLE);
         timer_osc_run <= !sleep_mode && timer_running(state_d);
      end
   end

   // ----------------------------------------------------------------
   // state report
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         charge_state <= TCS_IDLE;
      end else if (ce) begin
         charge_state <= state_d;
      end
   end

   // temperature classes come in ready made from the comparators

endmodule : tcs_sequencer

`default_nettype wire

// ---- core/tcs_sync.sv ----
`timescale 1ns/1ps
`default_nettype none

// two-stage level synchroniser for a bundle of comparator results
module tcs_sync
   import tcs_pkg::*;
#(
   parameter int unsigned WIDTH = CMP_W
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_q;

   // ----------------------------------------------------------------
   // first stage feeds only the second
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         meta_q <= '0;
         sync_out <= '0;
      end else if (ce) begin
         meta_q <= async_in;
         sync_out <= meta_q;
      end
   end

endmodule : tcs_sync

`default_nettype wire

// ---- verification/tcs_pack_model.sv ----
`timescale 1ns/1ps
`default_nettype none

// pack, thermistor and power stage as seen through the comparators
module tcs_pack_model
   import tcs_pkg::*;
(
   input wire logic clk,
   input wire logic charge_switch_output,
   input wire logic [1:0] temp_class,
   input wire logic full,
   input wire logic [1:0] timer_parts,
   output var tcs_cmp_t cmp_raw
);
   logic [3:0] cur_q = 4'h5;

   // inductor current climbs while switched on, drops to bias when off
   always @(posedge clk) begin
      if (charge_switch_output) cur_q <= (cur_q == 4'hf) ? cur_q : cur_q + 4'h1;
      else cur_q <= 4'h5;
   end

   // class 0 normal, 1 cold, 2 hot, 3 over-temperature (hot as well)
   always_comb begin
      cmp_raw.cold = (temp_class == 2'h1);
      cmp_raw.hot = temp_class[1];
      cmp_raw.overtemp = (temp_class == 2'h3);
      cmp_raw.at_max = full;
      cmp_raw.sense_above_low = (cur_q > 4'h2);
      cmp_raw.sense_below_high = (cur_q < 4'ha);
      cmp_raw.cap_large = timer_parts[1];
      cmp_raw.res_small = timer_parts[0];
   end
endmodule : tcs_pack_model

`default_nettype wire

// ---- verification/tcs_sequencer_props.sv ----
`timescale 1ns/1ps
`default_nettype none

// maintenance charge checks on the sequencer ports
module tcs_sequencer_props
   import tcs_pkg::*;
#(
   parameter int unsigned TICK_CYC = TICK_CYCLES,
   parameter int unsigned SEC_TICKS = SECOND_TICKS
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   input wire logic charge_init,
   input wire logic fast_charge_done,
   input wire logic sleep_mode,
   input wire logic temp_sampling,
   input wire logic [TIME_W-1:0] max_charge_time,
   input wire logic [SEL_W-1:0] trickle_width_sel,
   input wire tcs_cmp_t cmp_raw,
   input wire logic charge_switch_output,
   input wire logic status_indicator_out,
   input wire logic status_indicator_oe,
   input wire logic timer_pin_pull_low,
   input wire logic timer_osc_run,
   input wire tcs_state_t charge_state
);
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   int hi_q;

   // length of the switch-on run inside top-off
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) hi_q <= 0;
      else if (ce) hi_q <= (charge_switch_output && charge_state == TCS_TOPOFF) ? hi_q + 1 : 0;
   end

   // causes held long enough to pass the synchroniser
   sequence s_sense_bad;
      (!cmp_raw.sense_above_low || !cmp_raw.sense_below_high || cmp_raw.at_max) [*5];
   endsequence
   sequence s_below_max;
      (!cmp_raw.at_max) [*4];
   endsequence

   chk_indicator_off_maint:
   assert property (charge_state inside {TCS_TOPOFF, TCS_TRICKLE} |-> !status_indicator_oe)
      else $error("indicator lit in top-off or trickle");
   chk_osc_when_timing:
   assert property (timer_osc_run |-> charge_state inside {TCS_TOPOFF, TCS_TOP_HOT})
      else $error("timer oscillates outside top-off");
   chk_sleep_pin_low:
   assert property (ce && sleep_mode |=> timer_pin_pull_low)
      else $error("timer pin not low in sleep");
   chk_switch_gate:
   assert property (s_sense_bad |-> !charge_switch_output)
      else $error("switch on outside sense band or at full cell");
   chk_done_holds:
   assert property (charge_state == TCS_DONE && !charge_init |=> charge_state == TCS_DONE)
      else $error("left done without charge initiation");
   chk_init_restart:
   assert property (ce && charge_init |=> charge_state == TCS_IDLE)
      else $error("charge initiation did not restart");
   chk_trickle_stays:
   assert property (s_below_max ##0 (charge_state == TCS_TRICKLE && !charge_init)
      |=> charge_state == TCS_TRICKLE) else $error("trickle left without cause");
   chk_topoff_width:
   assert property (charge_state == TCS_TOPOFF |-> hi_q <= TOPOFF_PULSE_TICKS * TICK_CYC)
      else $error("top-off pulse too long");
endmodule : tcs_sequencer_props

bind tcs_sequencer tcs_sequencer_props #(.TICK_CYC(TICK_CYC), .SEC_TICKS(SEC_TICKS)) chk_u (
   .clk(clk), .nrst(nrst), .ce(ce), .charge_init(charge_init),
   .fast_charge_done(fast_charge_done), .sleep_mode(sleep_mode),
   .temp_sampling(temp_sampling),
   .max_charge_time(max_charge_time), .trickle_width_sel(trickle_width_sel),
   .cmp_raw(cmp_raw), .charge_switch_output(charge_switch_output),
   .status_indicator_out(status_indicator_out), .status_indicator_oe(status_indicator_oe),
   .timer_pin_pull_low(timer_pin_pull_low), .timer_osc_run(timer_osc_run),
   .charge_state(charge_state)
);

`default_nettype wire

// ---- verification/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none

module testbench
   import tcs_pkg::*;
;
   localparam int TC = 4;
   localparam int SEC = TC * 200;
   logic clk = 1'b0, nrst = 1'b0, init = 1'b0, fcd = 1'b0, slp = 1'b0, tss = 1'b0, full = 1'b0;
   logic [1:0] temp = 2'h0, tmr_parts = 2'h3;
   logic [TIME_W-1:0] mct = 16'h0005;
   logic [SEL_W-1:0] sel = 8'h01;
   logic sw, ind_oe, ind_out, pull, osc;
   logic ce = 1'b1;
   tcs_cmp_t cmp;
   tcs_state_t st, last = TCS_IDLE;
   tcs_state_t exp_q[$];
   int failures = 0, samples_checked = 0, hi;

   always #4 clk = ~clk;

   tcs_sequencer #(.TICK_CYC(TC), .SEC_TICKS(200)) dut_u (.clk(clk), .nrst(nrst), .ce(ce),
      .charge_init(init), .fast_charge_done(fcd), .sleep_mode(slp), .temp_sampling(tss),
      .max_charge_time(mct), .trickle_width_sel(sel), .cmp_raw(cmp),
      .charge_switch_output(sw), .status_indicator_out(ind_out), .status_indicator_oe(ind_oe),
      .timer_pin_pull_low(pull), .timer_osc_run(osc), .charge_state(st));
   tcs_pack_model pack_u (.clk(clk), .charge_switch_output(sw), .temp_class(temp),
      .full(full), .timer_parts(tmr_parts), .cmp_raw(cmp));

   // ------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic give_verdict;
      if (failures == 0 && samples_checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : give_verdict
   // wait for every noted state to show up
   task automatic settle;
      for (int i = 0; i < 8 * SEC && exp_q.size() != 0; i++) @(negedge clk);
      check(exp_q.size(), 0);
      repeat (8) @(negedge clk);
   endtask : settle
   // count switch-on cycles over n cycles
   task automatic watch(input int n);
      hi = 0;
      repeat (n) begin
         @(negedge clk);
         hi += sw;
      end
   endtask : watch
   task automatic pulse(ref logic s);
      s = 1'b1;
      @(negedge clk);
      s = 1'b0;
   endtask : pulse

   // each state change is matched with the oldest noted one
   always @(posedge clk) begin
      if (nrst && st !== last) begin
         check(st, exp_q.size() ? exp_q.pop_front() : 7'h00);
         last <= st;
      end
   end

   initial begin
      #(SEC * 8 * 75);
      failures++;
      give_verdict;
   end

   initial begin
      void'($urandom(32'h8333));
      sel = 8'($urandom_range(20, 1));
      mct = 16'($urandom_range(6, 5));
      repeat (2) @(negedge clk);
      nrst = 1'b1;
      tss = 1'b1;
      repeat (2) @(negedge clk);
      check({pull, ind_oe, ind_out}, 3'b110);
      tss = 1'b0;
      // top-off with cold, hot and expiry
      exp_q.push_back(TCS_TOPOFF);
      pulse(fcd);
      settle;
      check({osc, ind_oe}, 2'b10);
      watch(SEC);
      check(hi > 0 && hi <= 125 * TC, 1);
      exp_q.push_back(TCS_TOP_COLD);
      temp = 2'h1;
      settle;
      check(osc, 1'b0);
      exp_q.push_back(TCS_TOPOFF);
      temp = 2'h0;
      settle;
      exp_q.push_back(TCS_TOP_HOT);
      temp = 2'h2;
      settle;
      watch(SEC);
      check({hi != 0, osc}, 2'b01);
      exp_q.push_back(TCS_TOPOFF);
      temp = 2'h0;
      settle;
      exp_q.push_back(TCS_TOP_HOT);
      temp = 2'h2;
      repeat ((mct + 1) * SEC) @(negedge clk);
      exp_q.push_back(TCS_TRICKLE);
      temp = 2'h0;
      settle;
      check({osc, ind_oe}, 2'b00);
      watch(SEC);
      check(hi > 0 && hi <= sel * 8, 1);
      temp = 2'h2;
      repeat (4) @(negedge clk);
      watch(SEC);
      check(hi, 0);
      temp = 2'h0;
      watch(SEC);
      check(hi > 0, 1);
      exp_q.push_back(TCS_DONE);
      full = 1'b1;
      settle;
      full = 1'b0;
      watch(SEC);
      check(hi, 0);
      // restart ignored while the clock enable is low
      ce = 1'b0;
      pulse(init);
      ce = 1'b1;
      repeat (2) @(negedge clk);
      check(st, TCS_DONE);
      exp_q.push_back(TCS_IDLE);
      pulse(init);
      settle;
      // top-off refused for every other timer component pairing
      for (int r = 0; r < 3; r++) begin
         tmr_parts = 2'(r);
         repeat (4) @(negedge clk);
         exp_q.push_back(TCS_TRICKLE);
         pulse(fcd);
         settle;
         temp = 2'h3;
         watch(SEC);
         check(hi, 0);
         temp = 2'h0;
         exp_q.push_back(TCS_IDLE);
         pulse(init);
         settle;
      end
      // top-off left on full cell, then on timer expiry alone
      tmr_parts = 2'h3;
      for (int k = 0; k < 2; k++) begin
         repeat (4) @(negedge clk);
         exp_q.push_back(TCS_TOPOFF);
         pulse(fcd);
         settle;
         exp_q.push_back(k ? TCS_TRICKLE : TCS_DONE);
         full = (k == 0);
         settle;
         full = 1'b0;
         check(osc, 1'b0);
         exp_q.push_back(TCS_IDLE);
         pulse(init);
         settle;
      end
      // over-temperature during top-off
      repeat (4) @(negedge clk);
      exp_q.push_back(TCS_TOPOFF);
      pulse(fcd);
      settle;
      exp_q.push_back(TCS_OT_HALT);
      temp = 2'h3;
      settle;
      temp = 2'h2;
      watch(SEC);
      check(hi, 0);
      exp_q.push_back(TCS_TRICKLE);
      temp = 2'h0;
      settle;
      slp = 1'b1;
      repeat (2) @(negedge clk);
      check({pull, osc}, 2'b10);
      give_verdict;
   end
endmodule : testbench

`default_nettype wire
